// ==== serial_mux_pkg.sv ====
// Package with register map, field positions, reset values and routing modes of the serial mux.
// Contract
// - Mode 000 default: port_a to fifo_uart, port_b to uart_b, port_c to uart_c.
// - Default: fifo_uart flow control and data reach port_a, data lines crossed.
// - Default: uart_b data crossed to port_b, uart_c data crossed to port_c.
// - Mode 001 snoop: uart_b receive copies fifo_uart receive; uart_b transmit unused.
// - Modes 1, 2, 4: port_b unavailable, its receive line held at 1.
// - Modes 1, 3, 4: port_a clear-to-send pin shown in port_a_cts_status.
// - Mode 010: port_a detached, its RTS and receive at 1, fifo_uart bridged to uart_b.
// - Modes 1, 2, 3: uart_c data crossed to port_c.
// - Mode 2: port_a_rts_ctrl drives fifo_uart CTS; fifo_uart RTS shown in status.
// - Mode 011: port_a data to uart_b, port_b data to fifo_uart.
// - Modes 3, 4: fifo_uart CTS held at 1 unless mode 4 emulation applies.
// - Modes 3, 4: DTR and RTS control bits driven onto port_a pins.
// - Mode 100: uart_b to port_a, uart_c bridged to fifo_uart, port_c receive at 1.
// - Mode 4: bridge_cts_ctrl drives fifo_uart CTS; its RTS shown in bridge_rts_status.
// - Multiplexed modes apply only while mux_enable is 1.
// - Reset: mux_enable 0, mode 000, port_a_rts_ctrl and bridge_cts_ctrl 1.
package serial_mux_pkg;

  // Byte offsets of the two registers on the bus.
  localparam logic [3:0] MUX_MODE_REG_OFFSET = 4'h0;
  localparam logic [3:0] FLOW_EMUL_REG_OFFSET = 4'h4;

  // Field positions in mux_mode_reg.
  localparam int MUX_ENABLE_BIT = 4;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_SEL_W = 3;

  // Field positions in flow_emul_reg.
  localparam int PORT_A_CTS_STATUS_BIT = 7;
  localparam int PORT_A_RTS_CTRL_BIT = 5;
  localparam int BRIDGE_RTS_STATUS_BIT = 4;
  localparam int BRIDGE_CTS_CTRL_BIT = 2;
  localparam int PORT_A_DTR_CTRL_BIT = 1;
  localparam int SPARE_CTRL_BIT = 0;

  // Reset values.
  localparam logic MUX_ENABLE_RST = 1'b0;
  localparam logic [2:0] MODE_SEL_RST = 3'h0;
  localparam logic PORT_A_RTS_CTRL_RST = 1'b1;
  localparam logic BRIDGE_CTS_CTRL_RST = 1'b1;
  localparam logic PORT_A_DTR_CTRL_RST = 1'b1;
  localparam logic SPARE_CTRL_RST = 1'b0;
  localparam logic STATUS_RST = 1'b1;
  localparam logic WAITREQUEST_RST = 1'b1;
  localparam logic [31:0] READDATA_RST = 32'h00000000;

  // Mode select codes.
  localparam logic [2:0] MODE_CODE_DEFAULT = 3'h0;
  localparam logic [2:0] MODE_CODE_SNOOP = 3'h1;
  localparam logic [2:0] MODE_CODE_BRIDGE_B = 3'h2;
  localparam logic [2:0] MODE_CODE_SWAP = 3'h3;
  localparam logic [2:0] MODE_CODE_BRIDGE_C = 3'h4;

  // Serial line idle (mark) level, also the inactive level of the low-active flow pins.
  localparam logic LINE_IDLE = 1'b1;

  // Positions in the registered pin output vector.
  localparam int PIN_W = 9;
  localparam int PIN_PORT_A_RX = 0;
  localparam int PIN_PORT_A_RTS = 1;
  localparam int PIN_PORT_A_DTR = 2;
  localparam int PIN_PORT_B_RX = 3;
  localparam int PIN_PORT_C_RX = 4;
  localparam int PIN_FIFO_RXD = 5;
  localparam int PIN_FIFO_CTS = 6;
  localparam int PIN_UART_B_RXD = 7;
  localparam int PIN_UART_C_RXD = 8;
  localparam logic [8:0] PIN_RST = 9'h1FF;

  typedef enum logic [2:0] {
    MODE_DEFAULT,
    MODE_SNOOP,
    MODE_BRIDGE_B,
    MODE_SWAP,
    MODE_BRIDGE_C
  } mux_mode_t;

endpackage : serial_mux_pkg

// ==== out_flop.sv ====
// Generic register with synchronous active-low reset to a parameter value.
module out_flop
  import serial_mux_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // Plain storage; every pin output of the mux leaves through one of these.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q <= RESET_VALUE;
    end else begin
      q <= d;
    end
  end

endmodule : out_flop

// ==== mode_decoder.sv ====
// Turns the enable bit and the mode field into the routing mode in force.
module mode_decoder
  import serial_mux_pkg::*;
(
  input wire logic muxEnable,
  input wire logic [2:0] modeSel,
  output mux_mode_t activeMode
);

  // Reserved codes fall back to the default routing so the pins never float undefined.
  always_comb begin
    activeMode = MODE_DEFAULT;
    if (muxEnable) begin
      unique case (modeSel)
        MODE_CODE_DEFAULT: activeMode = MODE_DEFAULT;
        MODE_CODE_SNOOP: activeMode = MODE_SNOOP;
        MODE_CODE_BRIDGE_B: activeMode = MODE_BRIDGE_B;
        MODE_CODE_SWAP: activeMode = MODE_SWAP;
        MODE_CODE_BRIDGE_C: activeMode = MODE_BRIDGE_C;
        default: activeMode = MODE_DEFAULT;
      endcase
    end
  end

endmodule : mode_decoder

// ==== serial_port_multiplexer.sv ====
// Serial port multiplexer: routes three serial units onto three external ports.
module serial_port_multiplexer
  import serial_mux_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  // Avalon-MM register slave.
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial units on the chip side.
  input wire logic fifoUartTxd,
  input wire logic fifoUartRtsN,
  input wire logic uartBTxd,
  input wire logic uartCTxd,
  output logic fifoUartRxd,
  output logic fifoUartCtsN,
  output logic uartBRxd,
  output logic uartCRxd,
  // External ports.
  input wire logic portATx,
  input wire logic portACtsN,
  input wire logic portBTx,
  input wire logic portCTx,
  output logic portARx,
  output logic portARtsN,
  output logic portADtrN,
  output logic portBRx,
  output logic portCRx
);

  // Control register state.
  logic muxEnable_ff;
  logic [2:0] modeSel_ff;
  logic portARtsCtrl_ff;
  logic bridgeCtsCtrl_ff;
  logic portADtrCtrl_ff;
  logic spareCtrl_ff;
  logic nxt_muxEnable;
  logic [2:0] nxt_modeSel;
  logic nxt_portARtsCtrl;
  logic nxt_bridgeCtsCtrl;
  logic nxt_portADtrCtrl;
  logic nxt_spareCtrl;

  // Status bits sampled from the lines.
  logic portACtsStatus_ff;
  logic bridgeRtsStatus_ff;
  logic nxt_portACtsStatus;
  logic nxt_bridgeRtsStatus;

  // Bus handshake state.
  // Both answer signals are registered, so the bus never sees a path from the lines.
  logic waitrequest_ff;
  logic [31:0] readdata_ff;
  logic nxt_waitrequest;
  logic [31:0] nxt_readdata;

  // Routing.
  mux_mode_t activeMode;
  logic [PIN_W-1:0] nxt_pins;
  logic [PIN_W-1:0] pins_ff;

  // Bus decode: an access is accepted in the cycle where waitrequest is already low.
  // Only the low byte lane carries register bits; a write with that lane off is dropped
  // whole, so a partial write can never change half of a field.
  wire request = read | write;
  wire firstCycle = request & waitrequest_ff;
  wire commit = write & ~waitrequest_ff;
  wire lowLaneOn = byteenable[0];
  wire addrModeReg = (address == MUX_MODE_REG_OFFSET);
  wire addrFlowReg = (address == FLOW_EMUL_REG_OFFSET);
  wire wrModeReg = commit & addrModeReg & lowLaneOn;
  wire wrFlowReg = commit & addrFlowReg & lowLaneOn;

  // Register images as software reads them; reserved bits read as zero.
  wire [7:0] modeRegImage = {3'h0, muxEnable_ff, 1'b0, modeSel_ff};
  wire [7:0] flowRegImage = {portACtsStatus_ff, 1'b0, portARtsCtrl_ff,
                             bridgeRtsStatus_ff, 1'b0, bridgeCtsCtrl_ff,
                             portADtrCtrl_ff, spareCtrl_ff};
  wire [7:0] selImage = addrModeReg ? modeRegImage :
                        addrFlowReg ? flowRegImage : 8'h00;

  // One wait cycle on every access: low for exactly one cycle, then high again.
  // Read data load in the first cycle and stand until the next read is taken.
  assign nxt_waitrequest = ~firstCycle;
  assign nxt_readdata = (firstCycle & read) ? {24'h000000, selImage} : readdata_ff;

  // Mode register writes; bit 3 is reserved and is not stored.
  // A new mode reaches the pins two edges after the write is accepted.
  assign nxt_muxEnable = wrModeReg ? writedata[MUX_ENABLE_BIT] : muxEnable_ff;
  assign nxt_modeSel = wrModeReg ? writedata[MODE_SEL_LSB +: MODE_SEL_W] : modeSel_ff;

  // Flow emulation register writes; status bits ignore writes.
  // The spare bit is plain storage that software may use freely.
  assign nxt_portARtsCtrl = wrFlowReg ? writedata[PORT_A_RTS_CTRL_BIT] : portARtsCtrl_ff;
  assign nxt_bridgeCtsCtrl = wrFlowReg ? writedata[BRIDGE_CTS_CTRL_BIT] : bridgeCtsCtrl_ff;
  assign nxt_portADtrCtrl = wrFlowReg ? writedata[PORT_A_DTR_CTRL_BIT] : portADtrCtrl_ff;
  assign nxt_spareCtrl = wrFlowReg ? writedata[SPARE_CTRL_BIT] : spareCtrl_ff;

  // mode register reset values.
  // Reset leaves multiplexing off, so every port starts on its own unit whatever
  // the mode field held before.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      muxEnable_ff <= MUX_ENABLE_RST;
      modeSel_ff <= MODE_SEL_RST;
    end else begin
      muxEnable_ff <= nxt_muxEnable;
      modeSel_ff <= nxt_modeSel;
    end
  end

  // flow emulation control reset values.
  // The RTS, DTR and bridge CTS controls wake up at the inactive level of the low-active flow lines, so no
  // far side sees a request to send before software has programmed one.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      portARtsCtrl_ff <= PORT_A_RTS_CTRL_RST;
      bridgeCtsCtrl_ff <= BRIDGE_CTS_CTRL_RST;
      portADtrCtrl_ff <= PORT_A_DTR_CTRL_RST;
      spareCtrl_ff <= SPARE_CTRL_RST;
    end else begin
      portARtsCtrl_ff <= nxt_portARtsCtrl;
      bridgeCtsCtrl_ff <= nxt_bridgeCtsCtrl;
      portADtrCtrl_ff <= nxt_portADtrCtrl;
      spareCtrl_ff <= nxt_spareCtrl;
    end
  end

  // Bus answer: waitrequest rests high and drops for one cycle per access.
  // Holding it high while idle costs a cycle per access, but the slave then never
  // accepts a request in the cycle in which it first decodes it.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      waitrequest_ff <= WAITREQUEST_RST;
      readdata_ff <= READDATA_RST;
    end else begin
      waitrequest_ff <= nxt_waitrequest;
      readdata_ff <= nxt_readdata;
    end
  end

  // Status sampling; a status bit reads its idle level in modes that do not drive it.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      portACtsStatus_ff <= STATUS_RST;
      bridgeRtsStatus_ff <= STATUS_RST;
    end else begin
      portACtsStatus_ff <= nxt_portACtsStatus;
      bridgeRtsStatus_ff <= nxt_bridgeRtsStatus;
    end
  end

  // The decoder is combinational; the pin register behind it hides any glitch.
  // mode applies only when enabled.
  mode_decoder u_mode_decoder (
    .muxEnable(muxEnable_ff),
    .modeSel(modeSel_ff),
    .activeMode(activeMode)
  );

  // Per-mode routing. Everything lands in one register stage, so a line change
  // reaches the far side one core_clk later; at 100 ns this is far below a bit time
  // of any usual baud rate, and it keeps every pin glitch free on mode changes.
  // Defaults give every pin its idle level, so each arm names only what it routes.
  always_comb begin
    nxt_pins = PIN_RST;
    nxt_portACtsStatus = STATUS_RST;
    nxt_bridgeRtsStatus = STATUS_RST;
    unique case (activeMode)
      MODE_DEFAULT: begin
        // Each port serves its own unit; data lines are crossed at the port.
        // one-to-one assignment.
        nxt_pins[PIN_PORT_A_RX] = fifoUartTxd;
        nxt_pins[PIN_FIFO_RXD] = portATx;
        nxt_pins[PIN_FIFO_CTS] = portACtsN;
        nxt_pins[PIN_PORT_A_RTS] = fifoUartRtsN;
        nxt_pins[PIN_PORT_B_RX] = uartBTxd;
        nxt_pins[PIN_UART_B_RXD] = portBTx;
        nxt_pins[PIN_PORT_C_RX] = uartCTxd;
        nxt_pins[PIN_UART_C_RXD] = portCTx;
      end
      MODE_SNOOP: begin
        // Port_a traffic stays on fifo_uart while uart_b listens to the same line.
        // snoop keeps fifo_uart on port_a.
        nxt_pins[PIN_PORT_A_RX] = fifoUartTxd;
        nxt_pins[PIN_FIFO_RXD] = portATx;
        nxt_pins[PIN_FIFO_CTS] = portACtsN;
        nxt_pins[PIN_PORT_A_RTS] = fifoUartRtsN;
        // uart_b listens to fifo_uart receive line.
        nxt_pins[PIN_UART_B_RXD] = portATx;
        nxt_pins[PIN_PORT_B_RX] = LINE_IDLE;
        nxt_pins[PIN_PORT_C_RX] = uartCTxd;
        nxt_pins[PIN_UART_C_RXD] = portCTx;
        nxt_portACtsStatus = portACtsN;
      end
      MODE_BRIDGE_B: begin
        // The fifo_uart unit talks to uart_b inside the chip; port_a and port_b rest.
        // port_a detached and idle.
        nxt_pins[PIN_PORT_A_RX] = LINE_IDLE;
        nxt_pins[PIN_PORT_A_RTS] = LINE_IDLE;
        nxt_pins[PIN_FIFO_RXD] = uartBTxd;
        nxt_pins[PIN_UART_B_RXD] = fifoUartTxd;
        nxt_pins[PIN_FIFO_CTS] = portARtsCtrl_ff;
        nxt_portACtsStatus = fifoUartRtsN;
        nxt_pins[PIN_PORT_B_RX] = LINE_IDLE;
        nxt_pins[PIN_PORT_C_RX] = uartCTxd;
        nxt_pins[PIN_UART_C_RXD] = portCTx;
      end
      MODE_SWAP: begin
        // The fifo_uart unit moves to port_b and uart_b takes port_a with emulated pins.
        // port_a data to uart_b.
        nxt_pins[PIN_PORT_A_RX] = uartBTxd;
        nxt_pins[PIN_UART_B_RXD] = portATx;
        nxt_pins[PIN_PORT_B_RX] = fifoUartTxd;
        nxt_pins[PIN_FIFO_RXD] = portBTx;
        nxt_pins[PIN_FIFO_CTS] = LINE_IDLE;
        nxt_pins[PIN_PORT_A_RTS] = portARtsCtrl_ff;
        nxt_pins[PIN_PORT_A_DTR] = portADtrCtrl_ff;
        nxt_pins[PIN_PORT_C_RX] = uartCTxd;
        nxt_pins[PIN_UART_C_RXD] = portCTx;
        nxt_portACtsStatus = portACtsN;
      end
      MODE_BRIDGE_C: begin
        // The fifo_uart unit talks to uart_c inside the chip; only port_a stays in use.
        // uart_b on port_a.
        nxt_pins[PIN_PORT_A_RX] = uartBTxd;
        nxt_pins[PIN_UART_B_RXD] = portATx;
        // uart_c bridged to fifo_uart, port_c idle.
        nxt_pins[PIN_UART_C_RXD] = fifoUartTxd;
        nxt_pins[PIN_FIFO_RXD] = uartCTxd;
        nxt_pins[PIN_PORT_C_RX] = LINE_IDLE;
        nxt_pins[PIN_PORT_B_RX] = LINE_IDLE;
        nxt_pins[PIN_FIFO_CTS] = bridgeCtsCtrl_ff;
        nxt_bridgeRtsStatus = fifoUartRtsN;
        nxt_pins[PIN_PORT_A_RTS] = portARtsCtrl_ff;
        nxt_pins[PIN_PORT_A_DTR] = portADtrCtrl_ff;
        nxt_portACtsStatus = portACtsN;
      end
    endcase
  end

  // Output stage; pins reset to the idle level.
  // A far side therefore sees a quiet mark level on every line during reset.
  out_flop #(
    .WIDTH(PIN_W),
    .RESET_VALUE(PIN_RST)
  ) u_pin_flop (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .d(nxt_pins),
    .q(pins_ff)
  );

  // Pin fan-out towards the external ports.
  assign portARx = pins_ff[PIN_PORT_A_RX];
  assign portARtsN = pins_ff[PIN_PORT_A_RTS];
  assign portADtrN = pins_ff[PIN_PORT_A_DTR];
  assign portBRx = pins_ff[PIN_PORT_B_RX];
  assign portCRx = pins_ff[PIN_PORT_C_RX];

  // Pin fan-out towards the serial units.
  assign fifoUartRxd = pins_ff[PIN_FIFO_RXD];
  assign fifoUartCtsN = pins_ff[PIN_FIFO_CTS];
  assign uartBRxd = pins_ff[PIN_UART_B_RXD];
  assign uartCRxd = pins_ff[PIN_UART_C_RXD];

  // Bus outputs.
  // They too come straight from flip-flops, as every output of this block does.
  assign waitrequest = waitrequest_ff;
  assign readdata = readdata_ff;

endmodule : serial_port_multiplexer

// ==== serial_port_multiplexer_chk.sv ====
// Checker that judges the multiplexer pins against the routing mode in force.
module serial_port_multiplexer_chk
  import serial_mux_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] address,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  input wire logic fifoUartTxd,
  input wire logic fifoUartRtsN,
  input wire logic uartBTxd,
  input wire logic uartCTxd,
  input wire logic portATx,
  input wire logic portACtsN,
  input wire logic portBTx,
  input wire logic fifoUartRxd,
  input wire logic fifoUartCtsN,
  input wire logic uartBRxd,
  input wire logic uartCRxd,
  input wire logic portARx,
  input wire logic portARtsN,
  input wire logic portADtrN,
  input wire logic portBRx,
  input wire logic portCRx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] mode_ff;
  logic rts_ff;
  logic dtr_ff;
  logic bcts_ff;
  logic [1:0] quiet_ff;
  // Reserved codes and a cleared enable both fall back to the one-to-one routing.
  wire logic commit = write && !waitrequest && byteenable[0];
  wire logic [2:0] nxt_mode = (writedata[4] && writedata[2:0] <= 3'h4) ? writedata[2:0] : 3'h0;
  wire logic [1:0] nxt_quiet = commit ? 2'h0 : (quiet_ff == 2'h3 ? 2'h3 : quiet_ff + 2'h1);
  wire logic ok = quiet_ff == 2'h3;
  // Pins lag a register write by two edges, so judging waits until the routing has settled.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mode_ff <= 3'h0;
      rts_ff <= 1'h1;
      dtr_ff <= 1'h1;
      bcts_ff <= 1'h1;
      quiet_ff <= 2'h0;
    end else begin
      quiet_ff <= nxt_quiet;
      if (commit && address == 4'h0) begin
        mode_ff <= nxt_mode;
      end
      if (commit && address == 4'h4) begin
        rts_ff <= writedata[5];
        bcts_ff <= writedata[2];
        dtr_ff <= writedata[1];
      end
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  property p_dflt;
    ok && mode_ff == 3'h0 |-> portARx == $past(fifoUartTxd) && fifoUartRxd == $past(portATx)
      && fifoUartCtsN == $past(portACtsN) && portARtsN == $past(fifoUartRtsN);
  endproperty
  a_dflt: assert property (p_dflt) else $error("default port_a routing wrong");
  property p_cross;
    ok && mode_ff == 3'h0 |-> portBRx == $past(uartBTxd) && uartBRxd == $past(portBTx);
  endproperty
  a_cross: assert property (p_cross) else $error("default port_b routing wrong");
  property p_snoop;
    ok && mode_ff == 3'h1 |-> uartBRxd == $past(portATx) && portARx == $past(fifoUartTxd);
  endproperty
  a_snoop: assert property (p_snoop) else $error("snoop routing wrong");
  property p_bidle;
    ok && mode_ff inside {3'h1, 3'h2, 3'h4} |-> portBRx;
  endproperty
  a_bidle: assert property (p_bidle) else $error("port_b receive not idle");
  property p_brb;
    ok && mode_ff == 3'h2 |-> portARx && portARtsN && fifoUartCtsN == rts_ff
      && fifoUartRxd == $past(uartBTxd) && uartBRxd == $past(fifoUartTxd);
  endproperty
  a_brb: assert property (p_brb) else $error("uart_b bridge wrong");
  property p_portc;
    ok && mode_ff inside {3'h1, 3'h2, 3'h3} |-> portCRx == $past(uartCTxd);
  endproperty
  a_portc: assert property (p_portc) else $error("port_c routing wrong");
  property p_swap;
    ok && mode_ff == 3'h3 |-> fifoUartRxd == $past(portBTx) && portBRx == $past(fifoUartTxd)
      && portARx == $past(uartBTxd) && fifoUartCtsN;
  endproperty
  a_swap: assert property (p_swap) else $error("swap routing wrong");
  property p_ctl;
    ok && mode_ff inside {3'h3, 3'h4} |-> portADtrN == dtr_ff && portARtsN == rts_ff;
  endproperty
  a_ctl: assert property (p_ctl) else $error("port_a control pins wrong");
  property p_brc;
    ok && mode_ff == 3'h4 |-> portCRx && fifoUartCtsN == bcts_ff
      && fifoUartRxd == $past(uartCTxd) && uartCRxd == $past(fifoUartTxd);
  endproperty
  a_brc: assert property (p_brc) else $error("uart_c bridge wrong");
endmodule : serial_port_multiplexer_chk

bind serial_port_multiplexer serial_port_multiplexer_chk u_chk (.core_clk, .reset_n, .address,
  .write, .writedata, .byteenable, .waitrequest, .fifoUartTxd, .fifoUartRtsN, .uartBTxd,
  .uartCTxd, .portATx, .portACtsN, .portBTx, .fifoUartRxd, .fifoUartCtsN, .uartBRxd, .uartCRxd,
  .portARx, .portARtsN, .portADtrN, .portBRx, .portCRx);

// ==== com_port_model.sv ====
// Behavioural model of the external serial port lines facing the multiplexer.
module com_port_model (
  input wire logic core_clk,
  input wire logic step,
  output logic portATx,
  output logic portACtsN,
  output logic portBTx,
  output logic portCTx
);
  timeunit 1ns;
  timeprecision 1ns;
  integer seed = 32'h6d1f;
  // Lines rest at the mark level until traffic starts, as an idle transceiver does;
  // each step then shows new levels and holds them, so the bench compares settled pins.
  initial begin
    {portATx, portACtsN, portBTx, portCTx} = 4'hF;
    forever begin
      @(posedge core_clk);
      if (step) begin
        {portATx, portACtsN, portBTx, portCTx} <= 4'($random(seed));
      end
    end
  end
endmodule : com_port_model

// ==== tb_serial_port_multiplexer.sv ====
// Self-checking bench for the serial port multiplexer.
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin nFail++; \
  $display("ERROR at %0t got %h expected %h", $time, (g), (e)); end end
module tb_serial_port_multiplexer
  import serial_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'h0;
  logic reset_n = 1'h0;
  logic [3:0] address = 4'h0;
  logic read = 1'h0;
  logic write = 1'h0;
  logic step = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic fifoUartTxd = 1'h1, fifoUartRtsN = 1'h1, uartBTxd = 1'h1, uartCTxd = 1'h1;
  logic [31:0] readdata;
  logic waitrequest, fifoUartRxd, fifoUartCtsN, uartBRxd, uartCRxd;
  logic portARx, portARtsN, portADtrN, portBRx, portCRx, portATx, portACtsN, portBTx, portCTx;
  int nFail = 0;
  int numChecks = 0;
  integer seed = 32'h6d1f;
  always #50 core_clk = ~core_clk;
  serial_port_multiplexer u_dut (.core_clk, .reset_n, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .fifoUartTxd, .fifoUartRtsN, .uartBTxd, .uartCTxd,
    .fifoUartRxd, .fifoUartCtsN, .uartBRxd, .uartCRxd, .portATx, .portACtsN, .portBTx, .portCTx,
    .portARx, .portARtsN, .portADtrN, .portBRx, .portCRx);
  com_port_model u_port (.core_clk, .step, .portATx, .portACtsN, .portBTx, .portCTx);
  // One bus access: the request stands until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
      output logic [31:0] q);
    @(posedge core_clk);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    do @(posedge core_clk); while (waitrequest !== 1'h0);
    q = readdata;
    write <= 1'h0;
    read <= 1'h0;
  endtask : bus
  // Expected pins {aRx, aRts, aDtr, bRx, cRx, fRxd, fCts, bRxd, cRxd} for a mode and controls.
  function automatic logic [8:0] route(input int m, input logic [7:0] c);
    case (m)
      1: return {fifoUartTxd, fifoUartRtsN, 2'h3, uartCTxd, portATx, portACtsN, portATx,
        portCTx};
      2: return {4'hF, uartCTxd, uartBTxd, c[5], fifoUartTxd, portCTx};
      3: return {uartBTxd, c[5], c[1], fifoUartTxd, uartCTxd, portBTx, 1'h1, portATx, portCTx};
      4: return {uartBTxd, c[5], c[1], 2'h3, uartCTxd, c[2], portATx, fifoUartTxd};
      default: return {fifoUartTxd, fifoUartRtsN, 1'h1, uartBTxd, uartCTxd, portATx, portACtsN,
        portBTx, portCTx};
    endcase
  endfunction : route
  task automatic reportAndStop();
    if (nFail == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : reportAndStop
  // A hang is cut short long after the roughly five hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge core_clk);
    nFail++;
    reportAndStop();
  end
  initial begin
    logic [31:0] q;
    logic [7:0] ctl;
    logic cs, br;
    int m;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'h1;
    bus(1'h0, 4'h0, 8'h0, q); `CHK(q, 32'h0)
    bus(1'h0, 4'h4, 8'h0, q); `CHK(q, 32'hB6)
    // Unmapped places and a disabled byte lane must leave the mode register alone.
    bus(1'h1, 4'h8, 8'h13, q);
    bus(1'h0, 4'h8, 8'h0, q); `CHK(q, 32'h0)
    byteenable <= 4'h0;
    bus(1'h1, 4'h0, 8'h13, q);
    byteenable <= 4'hF;
    bus(1'h0, 4'h0, 8'h0, q); `CHK(q, 32'h0)
    for (int e = 0; e < 2; e++) begin
      for (int s = 0; s < 8; s++) begin
        // Software keeps to the five defined codes, whatever the enable bit holds.
        if (s > 4) continue;
        m = (e == 1) ? s : 0;
        bus(1'h1, 4'h0, 8'((e << 4) | s), q);
        bus(1'h0, 4'h0, 8'h0, q); `CHK(q, 32'((e << 4) | s))
        for (int k = 0; k < 4; k++) begin
          ctl = 8'($random(seed));
          bus(1'h1, 4'h4, ctl, q);
          @(posedge core_clk);
          {fifoUartTxd, fifoUartRtsN, uartBTxd, uartCTxd} <= 4'($random(seed));
          step <= 1'h1;
          @(posedge core_clk);
          step <= 1'h0;
          repeat (3) @(posedge core_clk);
          `CHK({portARx, portARtsN, portADtrN, portBRx, portCRx, fifoUartRxd, fifoUartCtsN,
            uartBRxd, uartCRxd}, route(m, ctl))
          cs = (m == 2) ? fifoUartRtsN : ((m == 1 || m >= 3) ? portACtsN : 1'h1);
          br = (m == 4) ? fifoUartRtsN : 1'h1;
          bus(1'h0, 4'h4, 8'h0, q);
          `CHK(q, {24'h0, cs, 1'h0, ctl[5], br, 1'h0, ctl[2:0]})
        end
      end
    end
    reportAndStop();
  end
endmodule : tb_serial_port_multiplexer
